// [hw/mpsc_cfg.svh]
// Offsets, field positions and reset values of the manual path switch register bank.
// Assumes it is included by bare name before any use of its macros.
// Functional notes
// - Negative line field bits 7:5 picks 000 open, 001 first host, 010 left audio, 011 second host.
// - Supply field bits 1:0 picks 00 open, 01 reserved, 10 to microphone, 11 to supply output.
// - Routing acts only while the manual mode enable bit of the control register at 02H is set.
// - The charger pass switch closes only while the supply input is valid.
// - Charge override bit 4 forces the active-low charger detect output low.
// - With bit 4 clear, charger detect is low for charger class accessories and high otherwise.
// - The override, microphone protection and D+ force bits act regardless of manual mode.
// - Charge override bit 3 enables microphone over-voltage protection.
// - Charge override bit 2 forces 0.6 V on the positive data line, only with a valid supply.
// - Attach field bits 4:2 needs field plus one consecutive identical ID readings to attach.
// - Field bits 3:2 sets one to four ID checks to confirm a resistor code change.
// - Field bits 1:0 gives maximum ID capacitance 500 pF, 1 nF, 1.5 nF or 2 nF.
// - The routing register resets to 00100111.
// - Attach field resets to three matches; check register resets to two checks and 1 nF.
// - The supply valid condition reads as status bit 2.
`ifndef MPSC_CFG_SVH
`define MPSC_CFG_SVH
`define MPSC_IDX_CTRL     6'h02
`define MPSC_IDX_STAT     6'h09
`define MPSC_IDX_ROUTE    6'h13
`define MPSC_IDX_CHG      6'h14
`define MPSC_IDX_ATT      6'h1b
`define MPSC_IDX_IDC      6'h1c
`define MPSC_CTRL_MAN_BIT 0
`define MPSC_STAT_VLD_BIT 2
`define MPSC_CHG_FORCE    4
`define MPSC_CHG_MICOVP   3
`define MPSC_CHG_DPFORCE  2
`define MPSC_RST_CTRL     8'h00
`define MPSC_RST_ROUTE    8'h27
`define MPSC_RST_CHG      8'h00
`define MPSC_RST_ATT      8'h08
`define MPSC_RST_IDC      8'h05
`define MPSC_MSK_CTRL     8'h01
`define MPSC_MSK_CHG      8'h1c
`define MPSC_MSK_ATT      8'h1c
`define MPSC_MSK_IDC      8'h0f
`define MPSC_RESP_OKAY    2'h0
`define MPSC_RESP_SLVERR  2'h2
`endif

// [hw/mpsc_pkg.sv]
// Types shared by the manual path switch register bank.
// Assumes nothing of its surroundings.
package mpsc_pkg;
  typedef enum logic [6:0] {
    SEL_NONE  = 7'h01,
    SEL_CTRL  = 7'h02,
    SEL_STAT  = 7'h04,
    SEL_ROUTE = 7'h08,
    SEL_CHG   = 7'h10,
    SEL_ATT   = 7'h20,
    SEL_IDC   = 7'h40
  } mpsc_sel_t;
endpackage : mpsc_pkg

// [hw/mpsc_sync_if.sv]
// Carrier between the pin synchroniser and the register bank.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none
interface mpsc_sync_if;
  logic raw;
  logic clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : mpsc_sync_if
`default_nettype wire

// [hw/mpsc_sync.sv]
// Three flip-flop pin synchroniser; output moves once the last two stages agree.
// Assumes an asynchronous pin on raw and clk_i as the only clock.
`timescale 1ns/1ns
`default_nettype none
module mpsc_sync (
  // Clock and reset
  input  wire logic    clk_i,
  input  wire logic    sys_rst_i,
  // Carrier
  mpsc_sync_if.sync    sif
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;
  logic q_nxt;

  assign q_nxt     = (s2_r == s3_r) ? s3_r : q_r;
  assign sif.clean = q_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_r  <= 1'b0;
    end else begin
      s1_r <= sif.raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end
endmodule : mpsc_sync
`default_nettype wire

// [hw/mpsc_top.sv]
// Manual path switch register bank with an AXI4-Lite slave and routing outputs.
// Assumes detection logic on clk_i feeds ID readings and the charger class flag.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "mpsc_cfg.svh"
`default_nettype none
module mpsc_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // Pin and detection inputs
  input  wire logic        supply_valid_flag_i,
  input  wire logic        charger_class_i,
  input  wire logic        id_sample_valid_i,
  input  wire logic [4:0]  id_code_i,
  input  wire logic        id_float_i,
  // Switch and analog controls, attach flag and resistor code
  output logic [2:0]       neg_sw_o,
  output logic [2:0]       pos_route_o,
  output logic             mic_sw_o,
  output logic             fet_close_o,
  output logic             charger_detect_out_n_o,
  output logic             mic_overvoltage_enable_o,
  output logic             dp_force_o,
  output logic [1:0]       max_cap_sel_o,
  output logic             attach_o,
  output logic [4:0]       res_code_o
);
  mpsc_sync_if sif ();
  logic        valid;
  assign sif.raw = supply_valid_flag_i;
  assign valid   = sif.clean;

  mpsc_sync u_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .sif       (sif)
  );

  function automatic mpsc_pkg::mpsc_sel_t mpsc_dec(input logic [7:0] a);
    if (a[1:0] != 2'h0) begin
      return mpsc_pkg::SEL_NONE;
    end else if (a[7:2] == `MPSC_IDX_CTRL) begin
      return mpsc_pkg::SEL_CTRL;
    end else if (a[7:2] == `MPSC_IDX_STAT) begin
      return mpsc_pkg::SEL_STAT;
    end else if (a[7:2] == `MPSC_IDX_ROUTE) begin
      return mpsc_pkg::SEL_ROUTE;
    end else if (a[7:2] == `MPSC_IDX_CHG) begin
      return mpsc_pkg::SEL_CHG;
    end else if (a[7:2] == `MPSC_IDX_ATT) begin
      return mpsc_pkg::SEL_ATT;
    end else if (a[7:2] == `MPSC_IDX_IDC) begin
      return mpsc_pkg::SEL_IDC;
    end
    return mpsc_pkg::SEL_NONE;
  endfunction : mpsc_dec

  // Bus state.
  logic                awready_r;
  logic                wready_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic [7:0]          awaddr_r;
  logic [7:0]          wdata_r;
  logic                wstrb_r;
  logic                arready_r;
  logic                rvalid_r;
  logic [1:0]          rresp_r;
  logic [7:0]          rdata_r;
  // Registers.
  logic [7:0]          ctrl_r;
  logic [7:0]          route_r;
  logic [7:0]          chg_r;
  logic [7:0]          att_r;
  logic [7:0]          idc_r;
  logic [7:0]          ctrl_nxt;
  logic [7:0]          route_nxt;
  logic [7:0]          chg_nxt;
  logic [7:0]          att_nxt;
  logic [7:0]          idc_nxt;

  mpsc_pkg::mpsc_sel_t wsel;
  mpsc_pkg::mpsc_sel_t rsel;
  logic                do_wr;
  logic                wr_lo;
  logic                ar_hs;
  logic [7:0]          rd_val;
  logic [7:0]          stat_val;

  assign wsel     = mpsc_dec(awaddr_r);
  assign rsel     = mpsc_dec(s_axi_araddr_i);
  assign do_wr    = !awready_r && !wready_r && !bvalid_r;
  assign wr_lo    = do_wr && wstrb_r;
  assign ar_hs    = s_axi_arvalid_i && arready_r;
  assign stat_val = {5'h00, valid, 2'h0};

  assign ctrl_nxt  = (wr_lo && wsel == mpsc_pkg::SEL_CTRL) ? (wdata_r & `MPSC_MSK_CTRL) : ctrl_r;
  assign route_nxt = (wr_lo && wsel == mpsc_pkg::SEL_ROUTE) ? wdata_r : route_r;
  assign chg_nxt   = (wr_lo && wsel == mpsc_pkg::SEL_CHG) ? (wdata_r & `MPSC_MSK_CHG) : chg_r;
  assign att_nxt   = (wr_lo && wsel == mpsc_pkg::SEL_ATT) ? (wdata_r & `MPSC_MSK_ATT) : att_r;
  assign idc_nxt   = (wr_lo && wsel == mpsc_pkg::SEL_IDC) ? (wdata_r & `MPSC_MSK_IDC) : idc_r;

  assign rd_val = (rsel == mpsc_pkg::SEL_CTRL)  ? ctrl_r :
                  (rsel == mpsc_pkg::SEL_STAT)  ? stat_val :
                  (rsel == mpsc_pkg::SEL_ROUTE) ? route_r :
                  (rsel == mpsc_pkg::SEL_CHG)   ? chg_r :
                  (rsel == mpsc_pkg::SEL_ATT)   ? att_r :
                  (rsel == mpsc_pkg::SEL_IDC)   ? idc_r : 8'h00;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `MPSC_RESP_OKAY;
      awaddr_r  <= 8'h00;
      wdata_r   <= 8'h00;
      wstrb_r   <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && awready_r) begin
        awready_r <= 1'b0;
        awaddr_r  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_r) begin
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata_i[7:0];
        wstrb_r  <= s_axi_wstrb_i[0];
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (wsel == mpsc_pkg::SEL_NONE) ? `MPSC_RESP_SLVERR : `MPSC_RESP_OKAY;
      end
      if (bvalid_r && s_axi_bready_i) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= `MPSC_RESP_OKAY;
      rdata_r   <= 8'h00;
    end else if (ar_hs) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_val;
      rresp_r   <= (rsel == mpsc_pkg::SEL_NONE) ? `MPSC_RESP_SLVERR : `MPSC_RESP_OKAY;
    end else if (rvalid_r && s_axi_rready_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r  <= `MPSC_RST_CTRL;
      route_r <= `MPSC_RST_ROUTE;
      chg_r   <= `MPSC_RST_CHG;
      att_r   <= `MPSC_RST_ATT;
      idc_r   <= `MPSC_RST_IDC;
    end else begin
      ctrl_r  <= ctrl_nxt;
      route_r <= route_nxt;
      chg_r   <= chg_nxt;
      att_r   <= att_nxt;
      idc_r   <= idc_nxt;
    end
  end

  // Routing decode, gated by manual mode; charger detect and D+ force are not gated.
  logic       man;
  logic [2:0] neg_sw_nxt;
  logic [2:0] pos_route_nxt;
  logic       mic_sw_nxt;
  logic       fet_nxt;
  logic       chg_det_n_nxt;
  logic       dp_force_nxt;

  assign man           = ctrl_r[`MPSC_CTRL_MAN_BIT];
  assign neg_sw_nxt    = !man ? 3'h0 :
                         (route_r[7:5] == 3'h1) ? 3'b001 :
                         (route_r[7:5] == 3'h2) ? 3'b010 :
                         (route_r[7:5] == 3'h3) ? 3'b100 : 3'h0;
  assign pos_route_nxt = man ? route_r[4:2] : 3'h0;
  assign mic_sw_nxt    = man && (route_r[1:0] == 2'h2);
  assign fet_nxt       = man && (route_r[1:0] == 2'h3) && valid;
  assign chg_det_n_nxt = !(chg_r[`MPSC_CHG_FORCE] || charger_class_i);
  assign dp_force_nxt  = chg_r[`MPSC_CHG_DPFORCE] && valid;

  // ID reading qualification.
  logic [4:0] last_code_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [3:0] att_need;
  logic [3:0] chk_need;
  logic       attach_nxt;
  logic [4:0] res_code_nxt;
  logic       same;

  assign same      = (id_code_i == last_code_r);
  assign cnt_nxt   = !same ? 4'h1 : (cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1;
  assign att_need  = {1'b0, att_r[4:2]} + 4'h1;
  assign chk_need  = {2'h0, idc_r[3:2]} + 4'h1;
  assign attach_nxt = id_float_i ? 1'b0 :
                      (id_sample_valid_i && !attach_o && cnt_nxt >= att_need) ? 1'b1 : attach_o;
  assign res_code_nxt = (id_sample_valid_i && !attach_o && attach_nxt) ? id_code_i :
                        (id_sample_valid_i && attach_o && !id_float_i && id_code_i != res_code_o &&
                         cnt_nxt >= chk_need) ? id_code_i : res_code_o;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      last_code_r <= 5'h00;
      cnt_r       <= 4'h0;
    end else if (id_float_i) begin
      cnt_r <= 4'h0;
    end else if (id_sample_valid_i) begin
      last_code_r <= id_code_i;
      cnt_r       <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      neg_sw_o                 <= 3'h0;
      pos_route_o              <= 3'h0;
      mic_sw_o                 <= 1'b0;
      fet_close_o              <= 1'b0;
      charger_detect_out_n_o   <= 1'b1;
      mic_overvoltage_enable_o <= 1'b0;
      dp_force_o               <= 1'b0;
      max_cap_sel_o            <= 2'h0;
      attach_o                 <= 1'b0;
      res_code_o               <= 5'h00;
    end else begin
      neg_sw_o                 <= neg_sw_nxt;
      pos_route_o              <= pos_route_nxt;
      mic_sw_o                 <= mic_sw_nxt;
      fet_close_o              <= fet_nxt;
      charger_detect_out_n_o   <= chg_det_n_nxt;
      mic_overvoltage_enable_o <= chg_r[`MPSC_CHG_MICOVP];
      dp_force_o               <= dp_force_nxt;
      max_cap_sel_o            <= idc_r[1:0];
      attach_o                 <= attach_nxt;
      res_code_o               <= res_code_nxt;
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o  = wready_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rresp_o   = rresp_r;
  assign s_axi_rdata_o   = {24'h000000, rdata_r};

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_neg_host1: assert property ((man && route_r[7:5] == 3'h1) |=> neg_sw_o == 3'b001)
    else $error("neg route host1 wrong");
  a_pos_route: assert property (man |=> pos_route_o == $past(route_r[4:2]))
    else $error("pos route mismatch");
  a_supply_resvd: assert property ((route_r[1:0] == 2'h1) |=> !mic_sw_o && !fet_close_o)
    else $error("reserved supply code closed a switch");
  a_manual_gate: assert property (!man |=> neg_sw_o == 3'h0 && !mic_sw_o && !fet_close_o)
    else $error("switch closed without manual mode");
  a_fet_valid: assert property (fet_close_o |-> $past(valid) && $past(route_r[1:0]) == 2'h3)
    else $error("fet closed without valid supply");
  a_chg_force: assert property (chg_r[4] |=> !charger_detect_out_n_o)
    else $error("charger detect not forced low");
  a_chg_normal: assert property (!chg_r[4] |=> charger_detect_out_n_o == !$past(charger_class_i))
    else $error("charger detect wrong in normal mode");
  a_mic_ovp: assert property (##1 mic_overvoltage_enable_o == $past(chg_r[3]))
    else $error("mic protection enable mismatch");
  a_dp_force: assert property (dp_force_o |-> $past(chg_r[2] && valid))
    else $error("D+ forced without valid supply");
  a_attach_count: assert property ((attach_o && !$past(attach_o)) |-> $past(cnt_nxt) >= $past(att_need))
    else $error("attach before enough matches");
  a_code_change: assert property ((attach_o && $past(attach_o) && res_code_o != $past(res_code_o))
                                  |-> $past(cnt_nxt) >= $past(chk_need))
    else $error("code change before enough checks");
  a_stat_bit: assert property (ar_hs && rsel == mpsc_pkg::SEL_STAT |=> rdata_r[2] == $past(valid))
    else $error("status valid bit wrong");
endmodule : mpsc_top
`default_nettype wire

// [tb/manual_path_switch_config_tb.sv]
// Self-checking bench for the manual path switch register bank, driven over AXI4-Lite.
// Assumes mpsc_top with a 25 MHz clock and the bus map of mpsc_cfg.svh.
`timescale 1ns/1ns
`include "mpsc_cfg.svh"
`default_nettype none
module manual_path_switch_config_tb;
  localparam logic [1:0] OK = `MPSC_RESP_OKAY;
  localparam logic [1:0] ER = `MPSC_RESP_SLVERR;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  awaddr    = 8'h00;
  logic [7:0]  araddr    = 8'h00;
  logic [31:0] wdata     = 32'h0;
  logic [3:0]  wstrb     = 4'h1;
  logic        awv       = 1'b0;
  logic        wv        = 1'b0;
  logic        bready    = 1'b0;
  logic        arv       = 1'b0;
  logic        rready    = 1'b0;
  logic        sv        = 1'b0;
  logic        cls       = 1'b0;
  logic        idv       = 1'b0;
  logic        idfl      = 1'b0;
  logic [4:0]  idc       = 5'h00;
  wire logic   awready, wready, bvalid, arready, rvalid, msw, fet, cdn, ovp, dpf, att;
  wire logic [1:0]  bresp, rresp, cap;
  wire logic [31:0] rdata;
  wire logic [2:0]  neg, pos;
  wire logic [4:0]  res;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          i;
  logic [7:0]  cv [3] = '{8'h00, 8'h06, 8'h05};
  logic [7:0]  rv [4] = '{8'h81, 8'h4a, 8'h6f, 8'h27};
  logic [7:0]  re [4] = '{8'h00, 8'h4a, 8'h8d, 8'h25};
  logic [2:0]  ka [2] = '{3'h0, 3'h7};
  logic [1:0]  ca [2] = '{2'h0, 2'h3};

  mpsc_top DUT (
    .clk_i                    (clk_i),
    .sys_rst_i                (sys_rst_i),
    .s_axi_awaddr_i           (awaddr),
    .s_axi_awvalid_i          (awv),
    .s_axi_awready_o          (awready),
    .s_axi_wdata_i            (wdata),
    .s_axi_wstrb_i            (wstrb),
    .s_axi_wvalid_i           (wv),
    .s_axi_wready_o           (wready),
    .s_axi_bresp_o            (bresp),
    .s_axi_bvalid_o           (bvalid),
    .s_axi_bready_i           (bready),
    .s_axi_araddr_i           (araddr),
    .s_axi_arvalid_i          (arv),
    .s_axi_arready_o          (arready),
    .s_axi_rdata_o            (rdata),
    .s_axi_rresp_o            (rresp),
    .s_axi_rvalid_o           (rvalid),
    .s_axi_rready_i           (rready),
    .supply_valid_flag_i      (sv),
    .charger_class_i          (cls),
    .id_sample_valid_i        (idv),
    .id_code_i                (idc),
    .id_float_i               (idfl),
    .neg_sw_o                 (neg),
    .pos_route_o              (pos),
    .mic_sw_o                 (msw),
    .fet_close_o              (fet),
    .charger_detect_out_n_o   (cdn),
    .mic_overvoltage_enable_o (ovp),
    .dp_force_o               (dpf),
    .max_cap_sel_o            (cap),
    .attach_o                 (att),
    .res_code_o               (res)
  );

  always #20 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done;
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  task automatic tk(input int c);
    repeat (c) @(posedge clk_i);
  endtask : tk

  task automatic wr(input logic [5:0] ix, input logic [7:0] v, input logic [3:0] st, input logic [1:0] er);
    awaddr <= {ix, 2'b00};
    wdata  <= {24'h0, v};
    wstrb  <= st;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready === 1'b1) awv <= 1'b0;
      if (wready === 1'b1) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    chk("bresp", {6'h0, er}, {6'h0, bresp});
  endtask : wr

  task automatic rd(input logic [5:0] ix, input logic [7:0] e, input logic [1:0] er);
    araddr <= {ix, 2'b00};
    arv    <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready === 1'b1) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    chk("rdata", e, rdata[7:0]);
    chk("rresp", {6'h0, er}, {6'h0, rresp});
  endtask : rd

  task automatic feed(input logic [4:0] c, input int n);
    if (n > 0) begin
      idc <= c;
      idv <= 1'b1;
      repeat (n) @(posedge clk_i);
      idv <= 1'b0;
    end
  endtask : feed

  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`MPSC_IDX_ROUTE, 8'h27, OK);
    rd(`MPSC_IDX_CHG, 8'h00, OK);
    rd(`MPSC_IDX_ATT, 8'h08, OK);
    rd(`MPSC_IDX_IDC, 8'h05, OK);
    chk("max_cap", 8'h01, {6'h0, cap});
    rd(6'h3f, 8'h00, ER);
    wr(6'h3f, 8'h55, 4'h1, ER);
    wr(`MPSC_IDX_IDC, 8'h0a, 4'h0, OK);
    rd(`MPSC_IDX_IDC, 8'h05, OK);
    for (i = 0; i < 4; i++) begin
      wr(`MPSC_IDX_IDC, i[7:0], 4'h1, OK);
      tk(2);
      chk("max_cap", i[7:0], {6'h0, cap});
    end
    sv <= 1'b1;
    tk(6);
    chk("chg_det_n", 8'h01, {7'h0, cdn});
    rd(`MPSC_IDX_STAT, 8'h04, OK);
    cls <= 1'b1;
    tk(2);
    chk("chg_det_n", 8'h00, {7'h0, cdn});
    cls <= 1'b0;
    for (i = 0; i < 3; i++) begin
      wr(`MPSC_IDX_CHG, 8'h10 >> i, 4'h1, OK);
      tk(2);
      chk("chg_out", cv[i], {5'h0, cdn, ovp, dpf});
    end
    sv <= 1'b0;
    tk(6);
    chk("dp_force", 8'h00, {7'h0, dpf});
    rd(`MPSC_IDX_STAT, 8'h00, OK);
    wr(`MPSC_IDX_ROUTE, 8'h27, 4'h1, OK);
    tk(2);
    chk("route_off", 8'h00, {neg, pos, msw, fet});
    wr(`MPSC_IDX_CTRL, 8'h01, 4'h1, OK);
    sv <= 1'b1;
    tk(6);
    for (i = 0; i < 4; i++) begin
      wr(`MPSC_IDX_ROUTE, 8'h00, 4'h1, OK);
      wr(`MPSC_IDX_ROUTE, rv[i], 4'h1, OK);
      tk(2);
      chk("route", re[i], {neg, pos, msw, fet});
    end
    sv <= 1'b0;
    tk(6);
    chk("fet_close", 8'h00, {7'h0, fet});
    for (i = 0; i < 2; i++) begin
      wr(`MPSC_IDX_ATT, {3'h0, ka[i], 2'h0}, 4'h1, OK);
      wr(`MPSC_IDX_IDC, {4'h0, ca[i], 2'h1}, 4'h1, OK);
      idfl <= 1'b1;
      @(posedge clk_i);
      idfl <= 1'b0;
      tk(2);
      feed(5'h0a, int'(ka[i]));
      tk(3);
      chk("attach", 8'h00, {7'h0, att});
      feed(5'h0a, 1);
      tk(2);
      chk("attach", 8'h01, {7'h0, att});
      chk("res_code", 8'h0a, {3'h0, res});
      feed(5'h15, int'(ca[i]));
      tk(2);
      chk("res_code", 8'h0a, {3'h0, res});
      feed(5'h15, 1);
      tk(2);
      chk("res_code", 8'h15, {3'h0, res});
    end
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end
endmodule : manual_path_switch_config_tb
`default_nettype wire
